/* File: gst_regs.vh */
`ifndef GST_REGS_VH
`define GST_REGS_VH

// ==========================================================================
// Register byte offsets
`define GST_OFF_CTRL      8'h00
`define GST_OFF_GATE      8'h04
`define GST_OFF_CNT_LO    8'h08
`define GST_OFF_CNT_HI    8'h0c
`define GST_OFF_OVF       8'h10

// ==========================================================================
// Timer control fields
`define GST_CTRL_ON       0
`define GST_CTRL_WIDE     1
`define GST_CTRL_NOSYNC   2
`define GST_CTRL_OSC      3
`define GST_CTRL_PS_LO    4
`define GST_CTRL_PS_HI    5
`define GST_CTRL_SRC_LO   6
`define GST_CTRL_SRC_HI   7
`define GST_CTRL_RESET    8'h00

// ==========================================================================
// Gate control fields
`define GST_GATE_SS_LO    0
`define GST_GATE_SS_HI    1
`define GST_GATE_VAL      2
`define GST_GATE_GO       3
`define GST_GATE_SPM      4
`define GST_GATE_TM       5
`define GST_GATE_POL      6
`define GST_GATE_EN       7
`define GST_GATE_RESET    8'h00

// ==========================================================================
// Overflow register fields
`define GST_OVF_FLAG      0
`define GST_OVF_EN        1

// ==========================================================================
// Encodings and counts
`define GST_SRC_INSTR     2'b00
`define GST_SRC_SYS       2'b01
`define GST_SRC_EXT       2'b10
`define GST_GSS_PIN       2'b00
`define GST_GSS_MATCH     2'b01
`define GST_GSS_CMP1      2'b10
`define GST_GSS_CMP2      2'b11
`define GST_INSTR_LAST    2'b11
`define GST_CNT_RESET     16'h0000
`define GST_CNT_MAX       16'hffff

`endif

/* File: gst_timer.v */
// Summary of operation
// (RULE_01) Source field picks instruction, system, external clock
// (RULE_02) External source: pin, or crystal when enabled
// (RULE_03) Prescale field divides by 1, 2, 4, 8
// (RULE_04) Oscillator enable bit powers the crystal
// (RULE_05) Sync-disable bit matters only for external source
// (RULE_06) Wide bit selects buffered 16-bit access
// (RULE_07) Low byte read/write moves high buffer
// (RULE_08) On bit runs or stops the timer
// (RULE_09) Gate enable qualifies counting by gate
// (RULE_10) Polarity bit sets gate active level
// (RULE_11) Toggle mode flips gate on rising edges
// (RULE_12) Single pulse logic may own the gate
// (RULE_13) Acquisition bit armed until pulse completes
// (RULE_14) Gate level bit shows current gate
// (RULE_15) Gate source field picks pin, match, comparators
// (RULE_16) Internal source counts prescaled clock ticks
// (RULE_17) Counter needs falling edge before first rise
// (RULE_18) Crystal mode forces pins input, reads zero
// (RULE_19) Software programs gate control before control
// (RULE_20) Software avoids system clock with capture/compare
// (RULE_21) Rollover sets flag, request only if enabled
// (RULE_22) Special event trigger clears the count; code skips the clear for external source with sync disabled
// (RULE_23) External clock passes two-stage synchroniser
`timescale 1ns/1ps
`default_nettype none
`include "gst_regs.vh"
module gst_timer #(
  parameter CNT_W = 16
) (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        ext_count_pin,
  input  wire        xtal_clk_in,
  input  wire        gate_pin,
  input  wire        cmp1_out,
  input  wire        cmp2_out,
  input  wire        companion_match,
  input  wire        special_event,
  input  wire [1:0]  osc_pin_in,
  input  wire [1:0]  port_direction,
  input  wire [1:0]  port_out,
  output reg  [1:0]  osc_pin_o,
  output reg  [1:0]  osc_pin_oe,
  output reg  [1:0]  port_read,
  output reg         osc_enable,
  output wire        irq
);

  // ========================================================================
  // Declarations
  reg  [7:0]       ctrl_q;
  reg  [7:0]       gate_q;
  reg  [CNT_W-1:0] cnt_q;
  reg  [7:0]       hbuf_q;
  reg              ovf_flag_q;
  reg              ovf_en_q;
  reg  [1:0]       div_q;
  reg  [2:0]       ps_q;
  reg  [1:0]       ext_sync_q;
  reg  [1:0]       xtal_sync_q;
  reg  [1:0]       gpin_sync_q;
  reg  [1:0]       c1_sync_q;
  reg  [1:0]       c2_sync_q;
  reg  [1:0]       osc_sync_q;
  reg              ext_prev_q;
  reg              need_fall_q;
  reg              gate_prev_q;
  reg              base_prev_q;
  reg              tff_q;
  reg              sp_open_q;
  reg              go_q;
  reg              gate_src;
  reg              src_tick;
  wire             ps_tick;
  wire             setup_ph;
  wire             access_ph;
  wire             wr;
  wire             mapped;
  wire             ext_sel;
  wire             ext_now;
  wire             ext_rise;
  wire             ext_fall;
  wire             pol_gate;
  wire             gate_rise;
  wire             base_gate;
  wire             base_rise;
  wire             base_fall;
  wire             gate_val;
  wire             cnt_en;
  wire             inc;
  wire             wr_lo;
  wire             wr_hi;
  wire             wr_ctrl;
  wire             wr_gate;
  wire             wr_ovf;
  wire             ovf_evt;
  wire [2:0]       ps_last;
  // Address match on one register offset
  function hit;
    input [7:0] addr;
    input [7:0] off;
    begin
      hit = (addr == off);
    end
  endfunction
  // ========================================================================
  // APB slave: zero wait states, read data captured in setup
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign wr        = access_ph & pwrite;
  assign pready    = 1'b1;
  assign mapped    = hit(paddr, `GST_OFF_CTRL) | hit(paddr, `GST_OFF_GATE) |
                     hit(paddr, `GST_OFF_CNT_LO) | hit(paddr, `GST_OFF_CNT_HI) |
                     hit(paddr, `GST_OFF_OVF);
  assign pslverr   = access_ph & ~mapped;
  assign wr_ctrl   = wr & hit(paddr, `GST_OFF_CTRL);
  assign wr_gate   = wr & hit(paddr, `GST_OFF_GATE);
  assign wr_lo     = wr & hit(paddr, `GST_OFF_CNT_LO);
  assign wr_hi     = wr & hit(paddr, `GST_OFF_CNT_HI);
  assign wr_ovf    = wr & hit(paddr, `GST_OFF_OVF);
  // Read data; in wide mode a low byte read snapshots the true high byte
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      prdata <= 32'h0000_0000;
      hbuf_q <= 8'h00;
    end
    else
    begin
      if (setup_ph & ~pwrite)
      begin
        prdata <= 32'h0000_0000;
        if (hit(paddr, `GST_OFF_CTRL))
          prdata[7:0] <= ctrl_q;
        if (hit(paddr, `GST_OFF_GATE))
          prdata[7:0] <= {gate_q[7:4], go_q, gate_val, gate_q[1:0]}; // RULE_14
        if (hit(paddr, `GST_OFF_CNT_LO))
          prdata[7:0] <= cnt_q[7:0];
        if (hit(paddr, `GST_OFF_CNT_HI))
          prdata[7:0] <= ctrl_q[`GST_CTRL_WIDE] ? hbuf_q : cnt_q[15:8]; // RULE_06
        if (hit(paddr, `GST_OFF_OVF))
          prdata[1:0] <= {ovf_en_q, ovf_flag_q};
      end
      // Snapshot makes a low-then-high pair immune to rollover
      if (setup_ph & ~pwrite & hit(paddr, `GST_OFF_CNT_LO) & ctrl_q[`GST_CTRL_WIDE])
        hbuf_q <= cnt_q[15:8]; // RULE_07
      else if (wr_hi & ctrl_q[`GST_CTRL_WIDE])
        hbuf_q <= pwdata[7:0]; // RULE_07
    end
  end
  // ========================================================================
  // Control registers
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      ctrl_q   <= `GST_CTRL_RESET;
      gate_q   <= `GST_GATE_RESET;
      ovf_en_q <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= pwdata[7:0];
      if (wr_gate)
        gate_q <= pwdata[7:0];
      if (wr_ovf)
        ovf_en_q <= pwdata[`GST_OVF_EN];
    end
  end
  // ========================================================================
  // Pin synchronisers; first stage feeds only the second
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      ext_sync_q  <= 2'b00;
      xtal_sync_q <= 2'b00;
      gpin_sync_q <= 2'b00;
      c1_sync_q   <= 2'b00;
      c2_sync_q   <= 2'b00;
      osc_sync_q  <= 2'b00;
    end
    else
    begin
      ext_sync_q  <= {ext_sync_q[0], ext_count_pin};  // RULE_23
      xtal_sync_q <= {xtal_sync_q[0], xtal_clk_in};   // RULE_23
      gpin_sync_q <= {gpin_sync_q[0], gate_pin};
      c1_sync_q   <= {c1_sync_q[0], cmp1_out};
      c2_sync_q   <= {c2_sync_q[0], cmp2_out};
      osc_sync_q  <= {osc_sync_q[0], osc_pin_in[0]};
    end
  end
  // ========================================================================
  // Crystal pins: forced to inputs and read as zero when enabled
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      osc_enable <= 1'b0;
      osc_pin_o  <= 2'b00;
      osc_pin_oe <= 2'b00;
      port_read  <= 2'b00;
    end
    else
    begin
      osc_enable <= ctrl_q[`GST_CTRL_OSC]; // RULE_04
      osc_pin_o  <= port_out;
      osc_pin_oe <= ctrl_q[`GST_CTRL_OSC] ? 2'b00 : ~port_direction; // RULE_18
      // Only pin 0 carries a sampled copy; pin 1 is the amplifier side
      port_read  <= ctrl_q[`GST_CTRL_OSC] ? 2'b00 : {1'b0, osc_sync_q[1]}; // RULE_18
    end
  end
  // ========================================================================
  // External clock edge detection
  assign ext_sel  = (ctrl_q[`GST_CTRL_SRC_HI:`GST_CTRL_SRC_LO] == `GST_SRC_EXT);
  assign ext_now  = ctrl_q[`GST_CTRL_OSC] ? xtal_sync_q[1] : ext_sync_q[1]; // RULE_02
  assign ext_rise = ext_now & ~ext_prev_q;
  assign ext_fall = ~ext_now & ext_prev_q;
  // A count write or disable re-arms the falling-edge requirement
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      ext_prev_q  <= 1'b0;
      need_fall_q <= 1'b1;
    end
    else
    begin
      ext_prev_q <= ext_now;
      if (~ctrl_q[`GST_CTRL_ON] | wr_lo | wr_hi)
        need_fall_q <= 1'b1; // RULE_17
      else if (ext_fall)
        need_fall_q <= 1'b0; // RULE_17
    end
  end
  // ========================================================================
  // Source tick selection
  always @*
  begin
    case (ctrl_q[`GST_CTRL_SRC_HI:`GST_CTRL_SRC_LO])
      `GST_SRC_INSTR: src_tick = (div_q == `GST_INSTR_LAST);  // RULE_01 RULE_16
      `GST_SRC_SYS:   src_tick = 1'b1;                         // RULE_01 RULE_16
      `GST_SRC_EXT:   src_tick = ext_rise & ~need_fall_q;      // RULE_01 RULE_17
      default:        src_tick = 1'b0;
    endcase
  end
  // Prescaler terminal count per ratio
  assign ps_last = (3'b001 << ctrl_q[`GST_CTRL_PS_HI:`GST_CTRL_PS_LO]) - 3'b001; // RULE_03
  assign ps_tick = src_tick & (ps_q == ps_last); // RULE_03
  // Instruction clock divider and prescaler
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      div_q <= 2'b00;
      ps_q  <= 3'b000;
    end
    else
    begin
      div_q <= div_q + 2'b01;
      if (wr_lo)
        ps_q <= 3'b000; // RULE_07
      else if (cnt_en & src_tick)
        ps_q <= ps_tick ? 3'b000 : ps_q + 3'b001; // RULE_03
    end
  end
  // ========================================================================
  // Gate path
  always @*
  begin
    case (gate_q[`GST_GATE_SS_HI:`GST_GATE_SS_LO])
      `GST_GSS_PIN:   gate_src = gpin_sync_q[1];  // RULE_15
      `GST_GSS_MATCH: gate_src = companion_match; // RULE_15
      `GST_GSS_CMP1:  gate_src = c1_sync_q[1];    // RULE_15
      `GST_GSS_CMP2:  gate_src = c2_sync_q[1];    // RULE_15
      default:        gate_src = 1'b0;
    endcase
  end
  assign pol_gate  = gate_q[`GST_GATE_POL] ? gate_src : ~gate_src; // RULE_10
  assign gate_rise = pol_gate & ~gate_prev_q;
  assign base_gate = gate_q[`GST_GATE_TM] ? tff_q : pol_gate; // RULE_11
  assign base_rise = base_gate & ~base_prev_q;
  assign base_fall = ~base_gate & base_prev_q;
  assign gate_val  = gate_q[`GST_GATE_SPM] ? sp_open_q : base_gate; // RULE_12
  // Toggle flip-flop and single-pulse sequencer
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      gate_prev_q <= 1'b0;
      base_prev_q <= 1'b0;
      tff_q       <= 1'b0;
      sp_open_q   <= 1'b0;
      go_q        <= 1'b0;
    end
    else
    begin
      gate_prev_q <= pol_gate;
      base_prev_q <= base_gate;
      if (~gate_q[`GST_GATE_TM])
        tff_q <= 1'b0; // RULE_11
      else if (gate_rise)
        tff_q <= ~tff_q; // RULE_11
      // Arming write wins, also in the cycle that turns the mode on
      if (wr_gate & pwdata[`GST_GATE_GO] & pwdata[`GST_GATE_SPM])
        go_q <= 1'b1; // RULE_13
      else if (~gate_q[`GST_GATE_SPM])
      begin
        go_q      <= 1'b0; // RULE_13
        sp_open_q <= 1'b0; // RULE_12
      end
      else if (go_q & ~sp_open_q & base_rise)
        sp_open_q <= 1'b1; // RULE_12
      else if (sp_open_q & base_fall)
      begin
        sp_open_q <= 1'b0; // RULE_13
        go_q      <= 1'b0; // RULE_13
      end
    end
  end
  // ========================================================================
  // Counter
  assign cnt_en  = ctrl_q[`GST_CTRL_ON] & (~gate_q[`GST_GATE_EN] | gate_val); // RULE_08 RULE_09
  assign inc     = cnt_en & ps_tick;
  assign ovf_evt = inc & (cnt_q == `GST_CNT_MAX);
  // Trigger reset dropped in unsynchronised counter mode
  always @(posedge ref_clk)
  begin
    if (rst)
      cnt_q <= `GST_CNT_RESET;
    else if (special_event & ~(ext_sel & ctrl_q[`GST_CTRL_NOSYNC])) // RULE_05
      cnt_q <= `GST_CNT_RESET; // RULE_22
    else if (wr_lo)
    begin
      cnt_q[7:0] <= pwdata[7:0];
      if (ctrl_q[`GST_CTRL_WIDE])
        cnt_q[15:8] <= hbuf_q; // RULE_07
    end
    else if (wr_hi & ~ctrl_q[`GST_CTRL_WIDE])
      cnt_q[15:8] <= pwdata[7:0]; // RULE_06
    else if (inc)
      cnt_q <= cnt_q + 16'h0001; // RULE_21
  end
  // ========================================================================
  // Overflow flag; a new overflow beats a same-cycle clear
  always @(posedge ref_clk)
  begin
    if (rst)
      ovf_flag_q <= 1'b0;
    else if (ovf_evt)
      ovf_flag_q <= 1'b1; // RULE_21
    else if (wr_ovf & pwdata[`GST_OVF_FLAG])
      ovf_flag_q <= 1'b0;
  end
  assign irq = ovf_flag_q & ovf_en_q; // RULE_21
endmodule // gst_timer

`default_nettype wire

/* File: gst_timer_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "gst_regs.vh"
module gst_timer_monitor (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [1:0]  port_out,
  input wire logic [1:0]  osc_pin_o,
  input wire logic [1:0]  osc_pin_oe,
  input wire logic [1:0]  port_read,
  input wire logic        osc_enable,
  input wire logic        irq
);
  wire logic unmap;
  wire logic rd_setup;
  wire logic wr_take;
  // ==========
  // Bus decode seen from the pins
  assign unmap    = !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10});
  assign rd_setup = psel && !penable && !pwrite;
  assign wr_take  = psel && penable && pwrite;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // ==========
  // Bus answers
  a_ready_always: assert property (pready)
    else $error("pready low");
  a_slverr_unmapped: assert property (psel && penable |-> pslverr == unmap)
    else $error("pslverr wrong in access");
  a_slverr_idle: assert property (!(psel && penable) |-> !pslverr)
    else $error("pslverr outside access");
  a_rd_upper_zero: assert property (rd_setup |=> prdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_rd_unmap_zero: assert property (rd_setup && unmap |=> prdata == 32'h00000000)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!rd_setup |=> $stable(prdata))
    else $error("prdata moved without read");
  // ==========
  // Oscillator pins and overflow request
  a_osc_follows_bit: assert property (wr_take && paddr == `GST_OFF_CTRL
    |-> ##2 osc_enable == $past(pwdata[3], 2))
    else $error("osc_enable not control bit 3");
  a_xtal_pins_input: assert property (osc_enable && $past(osc_enable)
    |-> osc_pin_oe == 2'b00 && port_read == 2'b00)
    else $error("crystal pins not input or read nonzero");
  a_pin_data_copy: assert property ($stable(port_out) ##1 $stable(port_out)
    |-> osc_pin_o == port_out)
    else $error("osc_pin_o not port_out");
  a_irq_masked: assert property (wr_take && paddr == `GST_OFF_OVF && !pwdata[1]
    |=> !irq)
    else $error("irq with enable clear");
  c_unmapped: cover property (psel && penable && unmap);
  c_osc_on: cover property ($rose(osc_enable));
  c_irq: cover property (irq);
endmodule // gst_timer_monitor
bind gst_timer gst_timer_monitor u_mon (.ref_clk, .rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .port_out, .osc_pin_o, .osc_pin_oe,
  .port_read, .osc_enable, .irq);
`default_nettype wire

/* File: gst_ext_src.sv */
`timescale 1ns/1ps
`default_nettype none
module gst_ext_src (
  input  wire logic ref_clk,
  input  wire logic osc_on,
  output var  logic ext_count_pin,
  output var  logic xtal_clk_in
);
  logic [2:0] div_q;
  initial
  begin
    ext_count_pin = 1'b0;
    xtal_clk_in   = 1'b0;
    div_q         = 3'h0;
  end
  // Crystal swings only while powered, period of ten clocks; rests low
  always @(posedge ref_clk)
  begin
    if (!osc_on)
    begin
      div_q       <= 3'h0;
      xtal_clk_in <= 1'b0;
    end
    else if (div_q == 3'h4)
    begin
      div_q       <= 3'h0;
      xtal_clk_in <= ~xtal_clk_in;
    end
    else
      div_q <= div_q + 3'h1;
  end
  // Pin pulses rise first, so the first one is never counted
  task automatic pulses(input int n, input int hw);
    repeat (n)
    begin
      repeat (hw) @(posedge ref_clk);
      ext_count_pin <= 1'b1;
      repeat (hw) @(posedge ref_clk);
      ext_count_pin <= 1'b0;
    end
  endtask
endmodule // gst_ext_src
`default_nettype wire

/* File: gst_timer_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "gst_regs.vh"
module gst_timer_tb_top;
  logic        ref_clk, rst, psel, penable, pwrite, special_event, se;
  logic [7:0]  paddr, v;
  logic [31:0] pwdata, rd;
  logic [3:0]  gsrc;
  logic [1:0]  osc_pin_in, port_direction, port_out;
  logic [15:0] lf, cnt;
  wire         pready, pslverr, osc_enable, irq, ext_count_pin, xtal_clk_in;
  wire         gate_pin, cmp1_out, cmp2_out, companion_match;
  wire [31:0]  prdata;
  wire [1:0]   osc_pin_oe, port_read;
  int          n_mismatch, n_tests, cyc, n;
  assign {cmp2_out, cmp1_out, companion_match, gate_pin} = gsrc;
  gst_timer DUT (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ext_count_pin, .xtal_clk_in, .gate_pin, .cmp1_out, .cmp2_out,
    .companion_match, .special_event, .osc_pin_in, .port_direction, .port_out,
    .osc_pin_o(), .osc_pin_oe, .port_read, .osc_enable, .irq);
  gst_ext_src u_src (.ref_clk, .osc_on(osc_enable), .ext_count_pin, .xtal_clk_in);
  // ==========
  // Clock, hang guard, random pin traffic
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    lf <= lfsr_next(lf);
    {osc_pin_in, port_direction, port_out} <= lf[5:0];
    if (cyc == 30000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end
  // ==========
  // Bus and compare helpers
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Clock phase of the count is unknown, so a small window is allowed
  task automatic chkr(input string nm, input int e, input logic [31:0] g);
    n_tests++;
    if (((g + 2 >= e) && (g <= e + 2)) !== 1'b1)
    begin
      n_mismatch++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  // Next value of the stimulus LFSR, seeded with 19
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // Ticks over k idle cycles plus the three edges of the stopping write
  function automatic int exp_ticks(input int s, input int p, input int k);
    return ((s == 1) ? k + 3 : (k + 3) / 4) >> p;
  endfunction
  task automatic rdcnt();
    apb(1'b0, `GST_OFF_CNT_LO, 0);
    cnt[7:0] = rd[7:0];
    apb(1'b0, `GST_OFF_CNT_HI, 0);
    cnt[15:8] = rd[7:0];
  endtask
  task automatic run(input logic [7:0] c, input int k);
    apb(1'b1, `GST_OFF_CNT_LO, 0);
    apb(1'b1, `GST_OFF_CNT_HI, 0);
    apb(1'b1, `GST_OFF_CTRL, c);
    repeat (k) @(posedge ref_clk);
    apb(1'b1, `GST_OFF_CTRL, 0);
    rdcnt();
  endtask
  task automatic lvl(input logic [3:0] g, input int b, input logic e);
    gsrc <= g;
    repeat (5) @(posedge ref_clk);
    apb(1'b0, `GST_OFF_GATE, 0);
    chk("gate bit", e, rd[b]);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ==========
  // Main sequence
  initial
  begin
    {psel, penable, pwrite, special_event, paddr, pwdata, gsrc} = 0;
    {osc_pin_in, port_direction, port_out, cyc, n_mismatch, n_tests} = 0;
    lf = 16'h0013;
    rst = 1'b1;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    for (int a = 0; a < 6; a++)
    begin
      apb(1'b0, 8'(a * 4), 0);
      chk("reset value", 0, rd & 32'hfffffffb);
    end
    chk("unmapped error", 1'b1, se);
    $display("done reset");
    // Gate control is written before control throughout
    repeat (4)
    begin
      v = lf[7:0];
      apb(1'b1, `GST_OFF_GATE, v & 8'he3);
      apb(1'b0, `GST_OFF_GATE, 0);
      chk("gate control", v & 8'he3, rd & 32'hfb);
      apb(1'b1, `GST_OFF_CTRL, v & 8'hf6);
      apb(1'b0, `GST_OFF_CTRL, 0);
      chk("control", v & 8'hf6, rd);
    end
    apb(1'b1, `GST_OFF_GATE, 0);
    for (int s = 0; s < 2; s++)
      for (int p = 0; p < 4; p++)
      begin
        run({s[1:0], p[1:0], 4'h1}, 200);
        chkr("ratio", exp_ticks(s, p, 200), cnt);
      end
    for (int k = 0; k < 2; k++)
    begin
      n = 2 + lf % 5;
      apb(1'b1, `GST_OFF_CNT_LO, 0);
      apb(1'b1, `GST_OFF_CNT_HI, 0);
      apb(1'b1, `GST_OFF_CTRL, k ? 8'h85 : 8'h81);
      u_src.pulses(n, 4);
      apb(1'b1, `GST_OFF_CTRL, 0);
      rdcnt();
      chk("pin count", n - 1, cnt);
    end
    apb(1'b1, `GST_OFF_CTRL, 8'h89);
    repeat (200) @(posedge ref_clk);
    chk("pin drive", 0, osc_pin_oe);
    chk("pin read", 0, port_read);
    run(8'h89, 200);
    chkr("crystal", 19, cnt);
    $display("done clocks");
    for (int s = 0; s < 4; s++)
    begin
      apb(1'b1, `GST_OFF_GATE, {6'h30, s[1:0]});
      lvl(~(4'h1 << s), 2, 1'b0);
      lvl(4'h1 << s, 2, 1'b1);
    end
    apb(1'b1, `GST_OFF_GATE, 8'h80);
    lvl(4'h0, 2, 1'b1);
    apb(1'b1, `GST_OFF_GATE, 8'hc0);
    run(8'h41, 50);
    chk("gated count", 0, cnt);
    apb(1'b1, `GST_OFF_GATE, 8'h40);
    run(8'h41, 50);
    chkr("ungated count", exp_ticks(1, 0, 50), cnt);
    apb(1'b1, `GST_OFF_GATE, 8'he0);
    lvl(4'h1, 2, 1'b1);
    lvl(4'h0, 2, 1'b1);
    lvl(4'h1, 2, 1'b0);
    // Gate low before arming, so the mode switch makes no edge
    gsrc <= 4'h0;
    apb(1'b1, `GST_OFF_GATE, 8'hd8);
    lvl(4'h0, 3, 1'b1);
    lvl(4'h1, 3, 1'b1);
    lvl(4'h0, 3, 1'b0);
    apb(1'b1, `GST_OFF_GATE, 8'hd8);
    apb(1'b1, `GST_OFF_GATE, 8'hc0);
    lvl(4'h0, 3, 1'b0);
    apb(1'b1, `GST_OFF_GATE, 0);
    $display("done gate");
    apb(1'b1, `GST_OFF_CTRL, 8'h02);
    apb(1'b1, `GST_OFF_CNT_HI, 8'h12);
    apb(1'b1, `GST_OFF_CNT_LO, 8'h34);
    rdcnt();
    chk("wide count", 16'h1234, cnt);
    apb(1'b1, `GST_OFF_CNT_HI, 8'hff);
    apb(1'b1, `GST_OFF_CNT_LO, 8'hf0);
    apb(1'b1, `GST_OFF_OVF, 2);
    apb(1'b1, `GST_OFF_CTRL, 8'h43);
    repeat (20) @(posedge ref_clk);
    apb(1'b1, `GST_OFF_CTRL, 8'h02);
    apb(1'b0, `GST_OFF_OVF, 0);
    chk("overflow", 3, rd);
    chk("irq", 1'b1, irq);
    apb(1'b1, `GST_OFF_OVF, 3);
    @(negedge ref_clk);
    chk("irq clear", 1'b0, irq);
    apb(1'b1, `GST_OFF_OVF, 0);
    // Trigger used with the instruction clock only
    apb(1'b1, `GST_OFF_CTRL, 8'h01);
    repeat (40) @(posedge ref_clk);
    special_event <= 1'b1;
    apb(1'b1, `GST_OFF_CTRL, 0);
    special_event <= 1'b0;
    rdcnt();
    chk("trigger clear", 0, cnt);
    $display("done wide and overflow");
    report_and_stop();
  end
endmodule // gst_timer_tb_top
`default_nettype wire
